// >>> hdl/analog_comparator_mode_control.sv
// Control of the converter in conversion and 8-bit comparator modes:
// mode select, compare value, start, done flag, skip and low-result move.
// Assumes the CPU core issues one operation per machine cycle on cpu_op_i
// and a plain register port with read data one cycle after the strobe.
//
// Overview of operation
// - Control bit 3 picks conversion (0) or comparator (1) mode.
// - Load op puts B in compare value high nibble, A in low nibble.
// - Entering comparator mode leaves the conversion result undefined.
// - Compare value is separate and survives return to conversion mode.
// - Compare value accesses work only in comparator mode.
// - DAC reference is supply over 256 times compare value.
// - In comparator mode done flag is 1 when input below reference.
// - Second irq control bit routes done flag to interrupt or skip.
// - Interrupt acknowledge or successful skip clears the done flag.
// - Comparator start ends eight machine cycles later with result.
// - Analog selection leaves port drivers active; port reads undefined.
// - Move low result puts result bits 1:0 in A high, zeros below.
// - Mode switch may set done; skip after write clears it.
// - Reset clears control register and done flag.
//
// Our own choices: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`include "adc_cmp_map.svh"
module analog_comparator_mode_control
   import adc_cmp_pkg::*;
#(
   parameter int CMP_LEN  = 8,
   parameter int CONV_LEN = 62
) (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // CPU operation port
   input  wire cpu_op_e     cpu_op_i,
   input  wire logic [3:0]  acc_a_i,
   input  wire logic [3:0]  acc_b_i,
   // Register port
   input  wire logic [3:0]  addr_i,
   input  wire logic [7:0]  wdata_i,
   input  wire logic        wr_i,
   input  wire logic        rd_i,
   output logic [7:0]       rdata_o,
   // Analog side
   input  wire logic [9:0]  analog_input_zero_i,
   input  wire logic [9:0]  analog_input_one_i,
   input  wire logic [9:0]  analog_input_two_i,
   input  wire logic [9:0]  analog_input_three_i,
   // Results to the CPU
   output logic             skip_o,
   output logic [3:0]       acc_a_o,
   output logic             acc_a_load_o,
   output logic             done_irq_req_o,
   output logic [1:0]       analog_select_o,
   output logic             irq_o
);
   ////////////////////////////////////////////////////////////////////////
   logic [3:0]  converter_control_reg_q;
   logic [3:0]  irq_control_reg_two_q;
   logic [7:0]  cmp_value_q;
   logic [9:0]  result_q;
   logic        convert_done_flag_q;
   logic [1:0]  irq_stat_q;
   logic [1:0]  irq_mask_q;
   logic [5:0]  cnt_q;
   logic [9:0]  vin;
   logic        below;
   conv_state_e state_q;

   logic        cmp_mode;
   logic        busy;
   logic        start_ok;
   logic        finish;
   logic        done_set;
   logic        done_clr;
   logic        skip_hit;
   logic        mode_leave;
   logic [1:0]  ev;

   function automatic logic wr_hit(input logic [3:0] a, input logic [3:0] offs);
      wr_hit = wr_i && (a == offs);
   endfunction : wr_hit

   assign cmp_mode   = converter_control_reg_q[`CTRL_MODE_BIT];
   assign busy       = (state_q != ST_IDLE);
   assign start_ok   = (cpu_op_i == OP_START) && !busy;
   assign finish     = busy && (cnt_q == 6'd1);
   assign skip_hit   = (cpu_op_i == OP_SKIP_DONE) && convert_done_flag_q
                       && !irq_control_reg_two_q[`IRQCTL_DONE_BIT];
   // Leaving comparator mode can glitch the flag on the real converter; the
   // same side effect is modelled so software recovery is exercised.
   assign mode_leave = wr_hit(addr_i, `CTRL_OFFS) && cmp_mode
                       && !wdata_i[`CTRL_MODE_BIT] && below;
   assign done_set   = (finish && (state_q == ST_CONVERT))
                       || (finish && (state_q == ST_COMPARE) && below)
                       || mode_leave;
   assign done_clr   = skip_hit
                       || ((cpu_op_i == OP_IRQ_ACK)
                           && irq_control_reg_two_q[`IRQCTL_DONE_BIT]);
   assign ev         = {finish && (state_q == ST_CONVERT),
                        finish && (state_q == ST_COMPARE)};

   ////////////////////////////////////////////////////////////////////////
   analog_mux u_mux (
      .clk_i                (clk_i),
      .rst_i                (rst_i),
      .sel_i                (converter_control_reg_q[1:0]),
      .analog_input_zero_i  (analog_input_zero_i),
      .analog_input_one_i   (analog_input_one_i),
      .analog_input_two_i   (analog_input_two_i),
      .analog_input_three_i (analog_input_three_i),
      .vin_o                (vin)
   );

   cmp_dac_ref u_ref (
      .clk_i      (clk_i),
      .rst_i      (rst_i),
      .cmp_mode_i (cmp_mode),
      .code_i     ({2'b00, cmp_value_q}),
      .vin_i      (vin),
      .below_o    (below)
   );

   ////////////////////////////////////////////////////////////////////////
   // Control registers
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         converter_control_reg_q <= `CTRL_RESET;
         irq_control_reg_two_q   <= `IRQCTL_RESET;
      end else begin
         // Mode changes while busy are software's fault; no interlock here
         if (wr_hit(addr_i, `CTRL_OFFS)) begin
            converter_control_reg_q <= wdata_i[3:0];
         end
         if (wr_hit(addr_i, `IRQCTL_OFFS)) begin
            irq_control_reg_two_q <= wdata_i[3:0];
         end
      end
   end

   // Compare value: kept across mode changes, guarded by mode
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         cmp_value_q <= `CMPVAL_RESET;
      end else if (cmp_mode) begin
         if (cpu_op_i == OP_LOAD_CMP) begin
            cmp_value_q <= {acc_b_i, acc_a_i};
         end else if (wr_hit(addr_i, `CMPVAL_OFFS)) begin
            cmp_value_q <= wdata_i;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Sequencer
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_q <= ST_IDLE;
         cnt_q   <= 6'd0;
      end else begin
         unique case (state_q)
            ST_IDLE: begin
               if (start_ok) begin
                  state_q <= cmp_mode ? ST_COMPARE : ST_CONVERT;
                  cnt_q   <= cmp_mode ? 6'(CMP_LEN) : 6'(CONV_LEN);
               end
            end
            ST_CONVERT, ST_COMPARE: begin
               cnt_q <= cnt_q - 6'd1;
               if (finish) begin
                  state_q <= ST_IDLE;
               end
            end
         endcase
      end
   end

   // Conversion result: simple capture of the selected input at the end.
   // On entering comparator mode the result is simply not maintained.
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         result_q <= `RESULT_RESET;
      end else if (finish && (state_q == ST_CONVERT)) begin
         result_q <= vin;
      end
   end

   // Done flag: set wins over clear
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         convert_done_flag_q <= 1'b0;
      end else if (done_set) begin
         convert_done_flag_q <= 1'b1;
      end else if (done_clr) begin
         convert_done_flag_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // CPU answers
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         skip_o         <= 1'b0;
         acc_a_o        <= 4'h0;
         acc_a_load_o   <= 1'b0;
         done_irq_req_o <= 1'b0;
      end else begin
         skip_o         <= skip_hit;
         acc_a_load_o   <= (cpu_op_i == OP_MOVE_LOW);
         acc_a_o        <= {result_q[1:0], 2'b00};
         done_irq_req_o <= convert_done_flag_q && !done_clr
                           && irq_control_reg_two_q[`IRQCTL_DONE_BIT];
      end
   end

   // Port drivers stay on; only the selector goes to the pin logic
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         analog_select_o <= 2'b00;
      end else begin
         analog_select_o <= converter_control_reg_q[1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Event status, write one to clear, set wins
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         irq_stat_q <= 2'b00;
         irq_mask_q <= 2'b00;
         irq_o      <= 1'b0;
      end else begin
         if (wr_hit(addr_i, `IRQ_STAT_OFFS)) begin
            irq_stat_q <= (irq_stat_q & ~wdata_i[1:0]) | ev;
         end else begin
            irq_stat_q <= irq_stat_q | ev;
         end
         if (wr_hit(addr_i, `IRQ_MASK_OFFS)) begin
            irq_mask_q <= wdata_i[1:0];
         end
         irq_o <= |(irq_stat_q & irq_mask_q);
      end
   end

   // Read port
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rdata_o <= 8'h00;
      end else if (rd_i) begin
         unique case (addr_i)
            `CTRL_OFFS:     rdata_o <= {4'h0, converter_control_reg_q};
            `IRQCTL_OFFS:   rdata_o <= {4'h0, irq_control_reg_two_q};
            `CMPVAL_OFFS:   rdata_o <= cmp_mode ? cmp_value_q : 8'h00;
            `RESULT_OFFS:   rdata_o <= result_q[9:2];
            `STATUS_OFFS:   rdata_o <= {6'h00, convert_done_flag_q, busy};
            `IRQ_STAT_OFFS: rdata_o <= {6'h00, irq_stat_q};
            `IRQ_MASK_OFFS: rdata_o <= {6'h00, irq_mask_q};
            default:        rdata_o <= 8'h00;
         endcase
      end else begin
         rdata_o <= 8'h00;
      end
   end
endmodule : analog_comparator_mode_control

// >>> hdl/analog_mux.sv
// Input selector for the four shared analog pins.
// Assumes pin codes are stable during a measurement.
`timescale 1ns/1ps
module analog_mux (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic [1:0]  sel_i,
   input  wire logic [9:0]  analog_input_zero_i,
   input  wire logic [9:0]  analog_input_one_i,
   input  wire logic [9:0]  analog_input_two_i,
   input  wire logic [9:0]  analog_input_three_i,
   output logic [9:0]       vin_o
);
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         vin_o <= 10'h000;
      end else begin
         unique case (sel_i)
            2'd0: vin_o <= analog_input_zero_i;
            2'd1: vin_o <= analog_input_one_i;
            2'd2: vin_o <= analog_input_two_i;
            2'd3: vin_o <= analog_input_three_i;
         endcase
      end
   end
endmodule : analog_mux

// >>> hdl/cmp_dac_ref.sv
// Reference generator for the internal DAC: turns a code into the compare
// threshold against the sampled analog input.
// Assumes analog inputs arrive as 10-bit codes scaled to the supply.
`timescale 1ns/1ps
module cmp_dac_ref
   import adc_cmp_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        cmp_mode_i,
   input  wire logic [9:0]  code_i,
   input  wire logic [9:0]  vin_i,
   output logic             below_o
);
   logic [9:0] vref;

   // Comparator mode: supply/256 * n, n scaled up to the 10-bit input range
   always_comb begin
      if (cmp_mode_i) begin
         vref = {code_i[7:0], 2'b00};
      end else begin
         vref = code_i;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         below_o <= 1'b0;
      end else begin
         below_o <= (vin_i < vref);
      end
   end
endmodule : cmp_dac_ref

// >>> inc/adc_cmp_map.svh
// Constants of the converter comparator control block: register layout,
// reset values and timing counts.
// Assumes inclusion from the package and design files by bare name.
`ifndef ADC_CMP_MAP_SVH
`define ADC_CMP_MAP_SVH

// Soft register offsets (word addresses on the plain port)
`define CTRL_OFFS        4'h0
`define IRQCTL_OFFS      4'h1
`define CMPVAL_OFFS      4'h2
`define RESULT_OFFS      4'h3
`define STATUS_OFFS      4'h4
`define IRQ_STAT_OFFS    4'h5
`define IRQ_MASK_OFFS    4'h6
`define ACC_OFFS         4'h7

// Converter control field positions
`define CTRL_MODE_BIT    3
`define CTRL_SPARE_BIT   2
`define CTRL_PIN_LSB     0
// Second interrupt control: bit 2 routes the done flag to interrupt
`define IRQCTL_DONE_BIT  2

// Reset values
`define CTRL_RESET       4'h0
`define IRQCTL_RESET     4'h0
`define CMPVAL_RESET     8'h00
`define RESULT_RESET     10'h000

// Timing
`define CMP_CYCLES       4'h8
`define CONV_CYCLES      6'h3E

// Status bits
`define ST_BUSY_BIT      0
`define ST_DONE_BIT      1
`define EV_CMP_BIT       0
`define EV_CONV_BIT      1

`endif

// >>> inc/adc_cmp_pkg.sv
// Types shared by the converter comparator control block.
// Assumes the map header sits in the include path.
package adc_cmp_pkg;
   typedef enum logic [2:0] {
      OP_NONE,
      OP_LOAD_CMP,
      OP_START,
      OP_SKIP_DONE,
      OP_MOVE_LOW,
      OP_IRQ_ACK
   } cpu_op_e;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_CONVERT,
      ST_COMPARE
   } conv_state_e;

   typedef logic [3:0] nibble_t;
endpackage : adc_cmp_pkg

// >>> test/acmc_properties.sv
// Port checker for the comparator control block.
// Assumes a bind onto analog_comparator_mode_control and the map header.
`timescale 1ns/1ps
`include "adc_cmp_map.svh"
module acmc_check
   import adc_cmp_pkg::*;
#(
   parameter int CMP_LEN  = 8,
   parameter int CONV_LEN = 62
) (
   input wire logic       clk_i,
   input wire logic       rst_i,
   input wire cpu_op_e    cpu_op_i,
   input wire logic [3:0] acc_a_i,
   input wire logic [3:0] acc_b_i,
   input wire logic [3:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic       wr_i,
   input wire logic       rd_i,
   input wire logic [7:0] rdata_o,
   input wire logic [9:0] analog_input_zero_i,
   input wire logic [9:0] analog_input_one_i,
   input wire logic [9:0] analog_input_two_i,
   input wire logic [9:0] analog_input_three_i,
   input wire logic       skip_o,
   input wire logic [3:0] acc_a_o,
   input wire logic       acc_a_load_o,
   input wire logic       done_irq_req_o,
   input wire logic [1:0] analog_select_o,
   input wire logic       irq_o
);
   logic       mode_q, route_q, end_q;
   logic [7:0] cv_q;
   logic [6:0] cnt_q;
   logic [9:0] vin;
   wire        below = vin < {cv_q, 2'h0};
   always_comb begin
      case (analog_select_o)
         2'h0: vin = analog_input_zero_i;
         2'h1: vin = analog_input_one_i;
         2'h2: vin = analog_input_two_i;
         default: vin = analog_input_three_i;
      endcase
   end
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         mode_q <= 1'h0;
         route_q <= 1'h0;
      end else if (wr_i && addr_i == `CTRL_OFFS) mode_q <= wdata_i[3];
      else if (wr_i && addr_i == `IRQCTL_OFFS) route_q <= wdata_i[2];
   end
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) cv_q <= 8'h00;
      else if (cpu_op_i == OP_LOAD_CMP && mode_q) cv_q <= {acc_b_i, acc_a_i};
      else if (wr_i && addr_i == `CMPVAL_OFFS && mode_q) cv_q <= wdata_i;
   end
   // Restarts while counting are ignored, so a design that restarts ends late
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) cnt_q <= 7'h00;
      else if (cpu_op_i == OP_START && cnt_q == 7'h00)
         cnt_q <= mode_q ? 7'(CMP_LEN) : 7'(CONV_LEN);
      else if (cnt_q != 7'h00) cnt_q <= cnt_q - 7'h01;
   end
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) end_q <= 1'h0;
      else end_q <= cnt_q == 7'h01;
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // Control write lands at the first edge, the registered pin copy at the next
   property p_sel;
      wr_i && addr_i == `CTRL_OFFS |-> ##2 analog_select_o == $past(wdata_i[1:0], 2);
   endproperty
   a_move_pulse: assert property (cpu_op_i == OP_MOVE_LOW |=> acc_a_load_o && acc_a_o[1:0] == 2'h0)
      else $error("move low pulse or low bits wrong");
   a_move_cause: assert property (acc_a_load_o |-> $past(cpu_op_i) == OP_MOVE_LOW)
      else $error("accumulator load without move op");
   a_skip_cause: assert property (skip_o |-> $past(cpu_op_i) == OP_SKIP_DONE && !$past(route_q))
      else $error("skip without skip op in skip routing");
   a_skip_clears: assert property (skip_o |=> !skip_o)
      else $error("flag not cleared by skip");
   a_sel_copy: assert property (p_sel)
      else $error("pin select not copied");
   a_cmpval_gated: assert property (rd_i && addr_i == `CMPVAL_OFFS && !mode_q |=> rdata_o == 8'h00)
      else $error("compare value readable in conversion mode");
   a_below_sets: assert property (end_q && mode_q && route_q && below |-> ##[0:1] done_irq_req_o)
      else $error("below input did not set done");
   a_done_timing: assert property ($rose(done_irq_req_o) |-> end_q || $past(end_q))
      else $error("done rose away from measurement end");
   a_done_holds: assert property (done_irq_req_o && cpu_op_i != OP_IRQ_ACK && !wr_i
      && $past(cpu_op_i) != OP_IRQ_ACK && !$past(wr_i) |=> done_irq_req_o)
      else $error("done dropped without acknowledge");
   c_skip: cover property (skip_o);
   c_move: cover property (acc_a_load_o);
   c_irq: cover property (irq_o);
   c_cmp_end: cover property (end_q && mode_q && route_q);
endmodule : acmc_check
bind analog_comparator_mode_control acmc_check #(.CMP_LEN(CMP_LEN), .CONV_LEN(CONV_LEN)) chk_u (.*);

// >>> test/cpu_model.sv
// CPU core model issuing one operation per machine cycle.
// Assumes the bench calls issue(); answers are judged by the bench.
`timescale 1ns/1ps
module cpu_model
   import adc_cmp_pkg::*;
(
   input  wire logic clk_i,
   output cpu_op_e   cpu_op_o,
   output nibble_t   acc_a_o,
   output nibble_t   acc_b_o
);
   initial begin
      cpu_op_o = OP_NONE;
      acc_a_o = 4'h0;
      acc_b_o = 4'h0;
   end
   // Accumulators flip once the op is gone so a late sample shows
   task automatic issue(input cpu_op_e op, input nibble_t a, input nibble_t b);
      @(posedge clk_i);
      cpu_op_o <= op;
      acc_a_o <= a;
      acc_b_o <= b;
      @(posedge clk_i);
      cpu_op_o <= OP_NONE;
      acc_a_o <= ~a;
      acc_b_o <= ~b;
   endtask : issue
endmodule : cpu_model

// >>> test/tb_analog_comparator_mode_control.sv
// Self-checking bench for the comparator control block.
// Assumes the map header in the include path and the CPU model beside it.
`timescale 1ns/1ps
`include "adc_cmp_map.svh"
module tb_analog_comparator_mode_control
   import adc_cmp_pkg::*;
;
   localparam int CL = 8;
   localparam int CV = 62;
   logic       clk_i = 1'h0, rst_i = 1'h1, wr_i = 1'h0, rd_i = 1'h0;
   logic [3:0] addr_i = 4'h0, acc_a_o;
   logic [7:0] wdata_i = 8'h00, rdata_o, got;
   logic [9:0] vin_q [4] = '{default: 10'h000};
   logic [1:0] analog_select_o;
   logic       skip_o, acc_a_load_o, done_irq_req_o, irq_o;
   logic [31:0] seed = 32'h25;
   cpu_op_e    cpu_op;
   nibble_t    acc_a, acc_b;
   int         failures = 0, comparisons = 0;
   always #50 clk_i = ~clk_i;
   cpu_model cpu_u (.clk_i(clk_i), .cpu_op_o(cpu_op), .acc_a_o(acc_a), .acc_b_o(acc_b));
   analog_comparator_mode_control #(.CMP_LEN(CL), .CONV_LEN(CV)) dut_u (
      .clk_i(clk_i), .rst_i(rst_i), .cpu_op_i(cpu_op), .acc_a_i(acc_a), .acc_b_i(acc_b),
      .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .analog_input_zero_i(vin_q[0]), .analog_input_one_i(vin_q[1]),
      .analog_input_two_i(vin_q[2]), .analog_input_three_i(vin_q[3]),
      .skip_o(skip_o), .acc_a_o(acc_a_o), .acc_a_load_o(acc_a_load_o),
      .done_irq_req_o(done_irq_req_o), .analog_select_o(analog_select_o), .irq_o(irq_o));
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs
   function automatic logic below(logic [9:0] v, logic [7:0] n);
      return v < {n, 2'h0};
   endfunction : below
   task automatic check_reg(string nm, logic [7:0] e, logic [7:0] g);
      comparisons++;
      if (g !== e) begin
         failures++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask : check_reg
   task automatic check_pin(string nm, logic e, logic g);
      check_reg(nm, {7'h00, e}, {7'h00, g});
   endtask : check_pin
   task automatic wr(logic [3:0] a, logic [7:0] d);
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'h1;
      @(posedge clk_i);
      wr_i <= 1'h0;
   endtask : wr
   task automatic rd(logic [3:0] a);
      @(posedge clk_i);
      addr_i <= a;
      rd_i <= 1'h1;
      @(posedge clk_i);
      rd_i <= 1'h0;
      #1 got = rdata_o;
   endtask : rd
   task automatic close_out();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : close_out
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      #2000000;
      failures++;
      close_out();
   end
   initial begin
      logic [31:0] r;
      logic [7:0]  n;
      logic [1:0]  p;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'h0;
      rd(`CTRL_OFFS);
      check_reg("ctrl", 8'h00, got);
      rd(`STATUS_OFFS);
      check_reg("status", 8'h00, got);
      wr(`CMPVAL_OFFS, 8'hA5);
      wr(`CTRL_OFFS, 8'h08);
      rd(`CMPVAL_OFFS);
      check_reg("cmpval", 8'h00, got);
      $display("test reset and access done");
      for (int i = 0; i < 8; i++) begin
         r = xs();
         n = r[15:8];
         p = r[1:0];
         @(posedge clk_i);
         vin_q[p] <= (i == 0) ? {n, 2'h0} - 10'h001 : (i == 1) ? {n, 2'h0} : r[25:16];
         wr(`CTRL_OFFS, {6'h02, p});
         cpu_u.issue(OP_LOAD_CMP, n[3:0], n[7:4]);
         #1 check_reg("select", {6'h00, p}, {6'h00, analog_select_o});
         cpu_u.issue(OP_START, 4'h0, 4'h0);
         // Second start lands mid-measurement and must be ignored
         cpu_u.issue(OP_START, 4'h0, 4'h0);
         rd(`STATUS_OFFS);
         check_reg("busy", 8'h01, got);
         repeat (CL) @(posedge clk_i);
         cpu_u.issue(OP_SKIP_DONE, 4'h0, 4'h0);
         #1 check_pin("skip", below(vin_q[p], n), skip_o);
         cpu_u.issue(OP_SKIP_DONE, 4'h0, 4'h0);
         #1 check_pin("skip again", 1'h0, skip_o);
      end
      check_pin("irq masked", 1'h0, irq_o);
      $display("test compare loop done");
      wr(`IRQCTL_OFFS, 8'h04);
      wr(`IRQ_STAT_OFFS, 8'hFF);
      wr(`IRQ_MASK_OFFS, 8'h01);
      rd(`IRQ_MASK_OFFS);
      check_reg("irq mask", 8'h01, got);
      @(posedge clk_i);
      vin_q[p] <= 10'h000;
      cpu_u.issue(OP_LOAD_CMP, 4'hF, 4'hF);
      cpu_u.issue(OP_START, 4'h0, 4'h0);
      repeat (CL + 2) @(posedge clk_i);
      #1 check_pin("done irq", 1'h1, done_irq_req_o);
      check_pin("irq", 1'h1, irq_o);
      cpu_u.issue(OP_SKIP_DONE, 4'h0, 4'h0);
      #1 check_pin("no skip", 1'h0, skip_o);
      cpu_u.issue(OP_IRQ_ACK, 4'h0, 4'h0);
      @(posedge clk_i);
      #1 check_pin("done ack", 1'h0, done_irq_req_o);
      rd(`IRQ_STAT_OFFS);
      check_reg("irq status", 8'h01, got);
      wr(`IRQ_STAT_OFFS, 8'h01);
      repeat (2) @(posedge clk_i);
      #1 check_pin("irq cleared", 1'h0, irq_o);
      $display("test interrupt done");
      wr(`IRQCTL_OFFS, 8'h00);
      wr(`CTRL_OFFS, 8'h01);
      cpu_u.issue(OP_SKIP_DONE, 4'h0, 4'h0);
      #1 check_pin("mode leave skip", 1'h1, skip_o);
      rd(`CMPVAL_OFFS);
      check_reg("cmpval conv", 8'h00, got);
      r = xs();
      @(posedge clk_i);
      vin_q[1] <= r[9:0];
      cpu_u.issue(OP_START, 4'h0, 4'h0);
      repeat (CV + 2) @(posedge clk_i);
      cpu_u.issue(OP_SKIP_DONE, 4'h0, 4'h0);
      #1 check_pin("conv skip", 1'h1, skip_o);
      rd(`RESULT_OFFS);
      check_reg("result", r[9:2], got);
      cpu_u.issue(OP_MOVE_LOW, 4'h0, 4'h0);
      #1 check_reg("move low", {4'h0, r[1:0], 2'h0}, {4'h0, acc_a_o});
      check_pin("move load", 1'h1, acc_a_load_o);
      wr(`CTRL_OFFS, 8'h08);
      rd(`CMPVAL_OFFS);
      check_reg("cmpval kept", 8'hFF, got);
      wr(`CMPVAL_OFFS, 8'h5A);
      rd(`CMPVAL_OFFS);
      check_reg("cmpval write", 8'h5A, got);
      $display("test mode switch done");
      close_out();
   end
endmodule : tb_analog_comparator_mode_control
